// [dv/can_timestamp_timer_sva.sv]
// Port checker of the time stamp timer.
`timescale 1ns/1ps
module can_timestamp_timer_sva import can_timestamp_pkg::*; #(parameter int CNT_W = 16) (
  input wire logic sys_clk, rst, read, write, waitrequest, captureStampEnable,
  input wire logic [ADDR_W-1:0] address, input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata, readdata, input wire logic [CNT_W-1:0] timestampCount);
  wire [CNT_W-1:0] c = timestampCount;
  wire en = captureStampEnable;
  wire wr = write && !waitrequest && address == TIMER_REG_ADDR;
  logic [15:0] pre_r;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst) pre_r <= '0;
    else if (wr) pre_r <= {byteenable[1] ? writedata[15:8] : pre_r[15:8],
                           byteenable[0] ? writedata[7:0] : pre_r[7:0]};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  cnt_clear_a: assert property (disable iff (1'b0) rst |=> c == '0) else $error("clear");
  cnt_step_a: assert property ($changed(c) && !$past(wr) |-> c == $past(c) + 1'b1)
    else $error("step");
  cnt_hold_a: assert property (!en && !wr |=> $stable(c)) else $error("hold");
  fast_step_a: assert property (en && pre_r < 2 && !wr |=> c == $past(c) + 1'b1)
    else $error("fast");
  cnt_load_a: assert property (wr && byteenable == 4'hf |=> c == $past(writedata[31:16]))
    else $error("load");
  pre_restart_a: assert property (wr && en && writedata[15:0] == 3 |=> ##1 $stable(c)[*2]
    ##1 c == $past(c) + 1'b1) else $error("restart");
  slow_step_a: assert property (wr && en && writedata[15:0] == '1 |=> ##1 $stable(c)[*8])
    else $error("slow");
  pre_read_a: assert property (!waitrequest && read && address == TIMER_REG_ADDR |->
    readdata[15:0] == pre_r) else $error("prescale");
  cover property (wr);
  cover property (en && c == '1);
  cover property (read && !waitrequest);
endmodule // can_timestamp_timer_sva
bind can_timestamp_timer can_timestamp_timer_sva #(.CNT_W(CNT_W)) u_sva (
  .sys_clk(sys_clk), .rst(rst), .read(read), .write(write), .waitrequest(waitrequest),
  .captureStampEnable(captureStampEnable), .address(address), .byteenable(byteenable),
  .writedata(writedata), .readdata(readdata), .timestampCount(timestampCount));

// [dv/can_timestamp_timer_tb.sv]
// Testbench of the time stamp timer.
`timescale 1ns/1ps
module can_timestamp_timer_tb;
  import can_timestamp_pkg::*;
  localparam logic [3:0] T = TIMER_REG_ADDR;
  logic sys_clk = 0, rst = 1, read = 0, write = 0, captureStampEnable = 0, waitrequest;
  logic [3:0] address = '0, byteenable = 4'hf;
  logic [31:0] writedata = '0, readdata, rd;
  logic [15:0] timestampCount, v;
  int fails = 0, samplesChecked = 0, cycles = 0;
  can_timestamp_timer u_dut (.sys_clk(sys_clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .captureStampEnable(captureStampEnable),
    .timestampCount(timestampCount));
  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++cycles == 80000) begin fails++; final_report; end
  task automatic final_report;
    $display("checks %0d fails %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    samplesChecked++;
    if (g !== e) begin fails++; $display("[FAIL] %s expected %h seen %h", s, e, g); end
  endtask
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    @(posedge sys_clk);
    read <= !w; write <= w; address <= a; writedata <= d;
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    rd = readdata; read <= 0; write <= 0;
  endtask
  task automatic span(int n, logic [15:0] d, string s);
    @(posedge sys_clk);
    v = timestampCount;
    repeat (n) @(posedge sys_clk);
    chk(s, {v + d}, timestampCount);
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 0;
    bus(0, T, 0); chk("reset", TIMER_REG_RESET, rd);
    bus(1, T, 32'h1234_0005); span(20, 0, "hold");
    bus(0, 4'h8, 0); chk("unmapped", UNMAPPED_DATA, rd);
    bus(1, T, 32'h10_0000); captureStampEnable <= 1; span(10, 10, "fast");
    bus(1, T, 32'hfffe_0003); span(12, 4, "wrap");
    byteenable <= 4'h3; bus(1, T, 4); v = timestampCount;
    repeat (9) bus(1, T, 4);
    chk("restart", v, timestampCount);
    captureStampEnable <= 0; byteenable <= 4'hf; bus(0, T, 0); chk("read", {v, 16'h4}, rd);
    captureStampEnable <= 1;
    repeat (3) @(posedge sys_clk);
    captureStampEnable <= 0; span(20, 0, "pause");
    captureStampEnable <= 1; span(1, 1, "resume");
    bus(1, T, 32'hffff); span(65534, 0, "slow");
    @(posedge sys_clk);
    chk("tick", 32'h1, timestampCount);
    final_report;
  end
endmodule // can_timestamp_timer_tb

// [hdl/can_timestamp_pkg.sv]
// Package with register map, field layout and reset values of the time stamp timer.
package can_timestamp_pkg;

  localparam int          ADDR_W           = 4;
  localparam logic [3:0]  TIMER_REG_ADDR   = 4'h0;
  localparam logic [3:0]  CONTROL_REG_ADDR = 4'h4;
  localparam int          CAPTURE_EN_BIT   = 0;
  localparam logic [31:0] TIMER_REG_RESET  = 32'h00000000;
  localparam logic [31:0] UNMAPPED_DATA    = 32'h00000000;
  localparam logic [15:0] COUNT_RESET      = 16'h0000;
  localparam logic [15:0] PRESCALE_RESET   = 16'h0000;
  localparam logic [15:0] PRESCALE_ZERO    = 16'h0000;
  localparam logic [15:0] COUNT_STEP       = 16'h0001;

  typedef struct packed {
    logic [15:0] timestampCount;
    logic [15:0] timestampPrescale;
  } timer_reg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } avmm_req_t;

endpackage

// [hdl/can_timestamp_timer.sv]
// Free-running 16-bit CAN time stamp timer with prescaler and Avalon-MM slave.
//
// What this block does
// - While capture enable is set the count advances once per prescaler period, unprompted.
// - A prescaler of all ones advances the count once every 65,535 system clocks.
// - A prescaler of zero advances the count on every system clock.
// - With capture enable clear, count and prescaler progress both stay frozen.
// - Any write to the timer register restarts the prescaler progress from zero.
// - The count sits in bits 31 to 16 of the timer register, read/write, zero at reset.
// - The prescaler sits in bits 15 to 0 of the timer register, read/write, zero at reset.
//
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module can_timestamp_timer
  import can_timestamp_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset.
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Avalon-MM slave.
  input  wire logic [ADDR_W-1:0]     address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  input  wire logic [3:0]            byteenable,
  output logic      [31:0]           readdata,
  output logic                       waitrequest,
  // Capture enable from the module control register.
  input  wire logic                  captureStampEnable,
  // Live timer state.
  output logic      [CNT_W-1:0]      timestampCount
);

  // Handshake states, Gray-coded along idle, answer and back to idle.
  typedef enum logic {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_t;

  // Byte lanes of the data bus.
  localparam int LANES  = 4;
  localparam int LANE_W = 8;

  bus_state_t        busState_r;
  bus_state_t        busState_nxt;
  logic              waitrequest_r;
  logic              waitrequest_nxt;
  logic [31:0]       readdata_r;
  logic [31:0]       readdata_nxt;
  logic [CNT_W-1:0]  count_r;
  logic [CNT_W-1:0]  count_nxt;
  logic [15:0]       prescale_r;
  logic [15:0]       prescale_nxt;
  logic [CNT_W-1:0]  preCnt_r;
  logic [CNT_W-1:0]  preCnt_nxt;
  logic              request;
  logic              accept;
  logic              complete;
  logic              timerSel;
  logic              timerWr;
  logic              enable;
  logic              prescaleZero;
  logic              prescaleDone;
  logic              tick;
  logic [15:0]       prescaleLast;
  timer_reg_t        timerCur;
  timer_reg_t        wrFields;
  wire logic [31:0]  timerWrVal;

  // A request is taken while idle and completes on the edge after that.
  // A write takes effect only at that completing edge, when waitrequest is low.
  assign request  = read || write;
  assign accept   = request && (busState_r == BUS_IDLE);
  assign complete = request && (busState_r == BUS_ANSWER);
  assign timerSel = (address == TIMER_REG_ADDR);
  assign timerWr  = complete && write && timerSel;

  // Zero and one in the prescaler both step the count on every clock.
  // The period minus one is the last progress value, so a period of N gives one tick in N clocks.
  assign enable       = captureStampEnable;
  assign timerCur     = {count_r, prescale_r};
  assign prescaleZero = (prescale_r == PRESCALE_ZERO);
  assign prescaleLast = prescale_r - COUNT_STEP;
  assign prescaleDone = (preCnt_r >= prescaleLast);
  assign tick         = enable && (prescaleZero || prescaleDone);
  assign wrFields     = timerWrVal;

  // Each enabled byte lane takes the new byte; the other lanes keep theirs.
  for (genvar lane = 0; lane < LANES; lane++) begin : g_lane
    assign timerWrVal[lane*LANE_W +: LANE_W] = byteenable[lane] ?
                                               writedata[lane*LANE_W +: LANE_W] :
                                               timerCur[lane*LANE_W +: LANE_W];
  end

  // Handshake state.
  // A request held past its answer is taken again, so the master drops it at once.
  always_comb begin
    busState_nxt = busState_r;
    case (busState_r)
      BUS_IDLE: begin
        if (request) begin
          busState_nxt = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        busState_nxt = BUS_IDLE;
      end
      default: begin
        busState_nxt = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busState_r <= BUS_IDLE;
    end else begin
      busState_r <= busState_nxt;
    end
  end

  // Waitrequest drops for exactly the one cycle in which the answer stands.
  always_comb begin
    waitrequest_nxt = 1'b1;
    if (accept) begin
      waitrequest_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      waitrequest_r <= 1'b1;
    end else begin
      waitrequest_r <= waitrequest_nxt;
    end
  end

  // Read data is latched when a read is taken, so it stands while waitrequest is low.
  // Any address other than the timer register reads as zero.
  always_comb begin
    readdata_nxt = readdata_r;
    if (accept && read) begin
      case (address)
        TIMER_REG_ADDR: begin
          readdata_nxt = timerCur;
        end
        default: begin
          readdata_nxt = UNMAPPED_DATA;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      readdata_r <= UNMAPPED_DATA;
    end else begin
      readdata_r <= readdata_nxt;
    end
  end

  // Prescaler progress; a write restarts it and a cleared enable freezes it.
  always_comb begin
    preCnt_nxt = preCnt_r;
    if (timerWr) begin
      preCnt_nxt = PRESCALE_RESET;
    end else if (!enable) begin
      preCnt_nxt = preCnt_r;
    end else if (tick) begin
      preCnt_nxt = PRESCALE_RESET;
    end else begin
      preCnt_nxt = preCnt_r + COUNT_STEP;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      preCnt_r <= PRESCALE_RESET;
    end else begin
      preCnt_r <= preCnt_nxt;
    end
  end

  // Count field; a software write wins over a tick in the same cycle.
  // The count wraps from all ones to zero and raises no flag.
  always_comb begin
    count_nxt = count_r;
    if (timerWr) begin
      count_nxt = wrFields.timestampCount;
    end else if (tick) begin
      count_nxt = count_r + COUNT_STEP;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_r <= COUNT_RESET;
    end else begin
      count_r <= count_nxt;
    end
  end

  // Prescaler field; only software changes it.
  always_comb begin
    prescale_nxt = prescale_r;
    if (timerWr) begin
      prescale_nxt = wrFields.timestampPrescale;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prescale_r <= PRESCALE_RESET;
    end else begin
      prescale_r <= prescale_nxt;
    end
  end

  // Outputs come straight from their registers.
  assign readdata       = readdata_r;
  assign waitrequest    = waitrequest_r;
  assign timestampCount = count_r;

endmodule // can_timestamp_timer
